/* opdec_pkg.sv */
// Purpose: Shared constants and helpers for the operand decoder and address generator
// Assumes: One core clock; one instruction cycle is eight clocks, two per quarter
// Notes: Register file index doubles as the 5-bit code's low bits for internal registers
// ============================================================

package opdec_pkg;

	// ============================================================
	// Instruction classes
	localparam logic [2:0] OP_MOVE = 3'h0;
	localparam logic [2:0] OP_ADD = 3'h1;
	localparam logic [2:0] OP_AND = 3'h2;
	localparam logic [2:0] OP_XOR = 3'h3;
	localparam logic [2:0] OP_EXEC_INDEXED = 3'h4;
	localparam logic [2:0] OP_BRANCH_NONZERO = 3'h5;
	localparam logic [2:0] OP_TRANSMIT_LITERAL = 3'h6;
	localparam logic [2:0] OP_JUMP_ABSOLUTE = 3'h7;

	// ============================================================
	// Special register indices
	localparam logic [3:0] REG_AUX = 4'h0;
	localparam logic [3:0] REG_LEFT_BANK_ADDR = 4'h7;
	localparam logic [3:0] REG_OVERFLOW = 4'h8;
	localparam logic [3:0] REG_LIT_OUT_A = 4'ha;
	localparam logic [3:0] REG_LIT_OUT_B = 4'hb;
	localparam logic [3:0] REG_RIGHT_BANK_ADDR = 4'hf;

	// ============================================================
	// Clock counts within one instruction cycle
	localparam logic [2:0] PH_FETCH = 3'h0;
	localparam logic [2:0] PH_IN_FIRST = 3'h2;
	localparam logic [2:0] PH_EXEC = 3'h4;
	localparam logic [2:0] PH_OUT_FIRST = 3'h5;
	localparam logic [2:0] PH_LATCH_FIRST = 3'h6;

	// ============================================================
	// Register bus map and reset values
	localparam logic [7:0] ADDR_REG_LAST = 8'h3c;
	localparam logic [7:0] ADDR_PC_STATUS = 8'h40;
	localparam logic [7:0] ADDR_INSTR_STATUS = 8'h44;
	localparam logic [12:0] PC_RESET = 13'h0000;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [15:0] INSTR_RESET = 16'h0000;

	function automatic logic [7:0] rotRight(input logic [7:0] v, input logic [2:0] n);
		logic [15:0] w;
		w = {v, v} >> n;
		return w[7:0];
	endfunction

	function automatic logic [7:0] lenMask(input logic [2:0] l);
		logic [8:0] m;
		m = (9'h001 << l) - 9'h001;
		return (l == 3'h0) ? 8'hff : m[7:0];
	endfunction

endpackage

/* operand_decode_addr_gen.sv */
// Purpose: Operand decode, I/O field align/mask/merge, next instruction address
// Assumes: Instruction and bus pins are asynchronous and pass two flip-flops
// Notes: Internal registers are readable and writable over APB for debug
//
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none

module operand_decode_addr_gen import opdec_pkg::*; (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [15:0] instrIn,
	output var logic [12:0] progAddr,
	input wire logic [7:0] ioDataBusIn,
	output var logic [7:0] ioDataBusOut,
	output var logic ioDataBusOe,
	output var logic leftBankSelectN,
	output var logic rightBankSelectN,
	output var logic addressStrobeCmd,
	output var logic writeStrobeCmd,
	output var logic masterLatchClock,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output var logic [31:0] prdata,
	output var logic pready,
	output var logic pslverr
);

	// ============================================================
	// State
	logic [2:0] cnt_q;
	logic [15:0] instrS1_q, instrS2_q, instr_q;
	logic [7:0] ioS1_q, ioS2_q;
	logic [12:0] pc_q;
	logic [7:0] rf_q [16];

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	// ============================================================
	// Field decode
	logic [2:0] op, lenField, srcPos, dstPos;
	logic [4:0] srcCode, dstCode;
	logic isAluOp, hasSrc, hasDst, srcIsReg, dstIsReg, srcRight, dstRight;
	assign op = instr_q[15:13];
	assign isAluOp = (op <= OP_XOR);
	assign hasSrc = (op != OP_TRANSMIT_LITERAL) && (op != OP_JUMP_ABSOLUTE);
	assign hasDst = isAluOp || (op == OP_TRANSMIT_LITERAL);
	assign srcCode = instr_q[12:8];
	assign dstCode = (op == OP_TRANSMIT_LITERAL) ? instr_q[12:8] : instr_q[4:0];
	assign srcIsReg = !srcCode[4];
	assign dstIsReg = !dstCode[4];
	assign srcRight = srcCode[3];
	assign dstRight = dstCode[3];
	assign srcPos = srcCode[2:0];
	assign dstPos = dstCode[2:0];
	assign lenField = instr_q[7:5];

	// Literal width follows the source kind; transmit looks at its destination kind
	logic litWide;
	logic [7:0] literal;
	assign litWide = (op == OP_TRANSMIT_LITERAL) ? dstIsReg : srcIsReg;
	assign literal = litWide ? instr_q[7:0] : {3'h0, instr_q[4:0]};

	// ============================================================
	// Source data
	logic [7:0] mask, srcReg, srcData;
	logic regToReg;
	assign mask = lenMask(lenField);
	assign regToReg = isAluOp && srcIsReg && dstIsReg;
	assign srcReg = rf_q[srcCode[3:0]];
	// Bank bit is not used by the shifter, so both banks behave alike
	// At the exec edge the synchroniser holds the byte caught while the source select was low
	assign srcData = !srcIsReg ? (rotRight(ioS2_q, srcPos) & mask) :
		regToReg ? rotRight(srcReg, lenField) : srcReg;

	// ============================================================
	// ALU
	logic [8:0] sum;
	logic [7:0] aluOut;
	assign sum = {1'b0, srcData} + {1'b0, rf_q[REG_AUX]};
	always_comb begin
		case (op)
			OP_ADD: aluOut = sum[7:0];
			OP_AND: aluOut = srcData & rf_q[REG_AUX];
			OP_XOR: aluOut = srcData ^ rf_q[REG_AUX];
			OP_TRANSMIT_LITERAL: aluOut = literal;
			default: aluOut = srcData;
		endcase
	end

	// ============================================================
	// Destination data
	logic [7:0] fieldMask, mergeBase, mergedOut;
	logic litToBus, dstBankAddr, dstBus, dstWrite;
	assign fieldMask = mask << dstPos;
	// Bus-to-bus reuses the byte just read; a register source merges into what the idle bus showed
	assign mergeBase = ioS2_q;
	assign mergedOut = (mergeBase & ~fieldMask) | ((aluOut << dstPos) & fieldMask);
	assign litToBus = (op == OP_TRANSMIT_LITERAL) && dstIsReg &&
		((dstCode[3:0] == REG_LIT_OUT_A) || (dstCode[3:0] == REG_LIT_OUT_B));
	assign dstBankAddr = hasDst && dstIsReg &&
		((dstCode[3:0] == REG_LEFT_BANK_ADDR) || (dstCode[3:0] == REG_RIGHT_BANK_ADDR));
	assign dstBus = hasDst && !dstIsReg;
	assign dstWrite = hasDst && dstIsReg && !litToBus;

	// ============================================================
	// Next address
	logic nzTaken, execEdge;
	logic [12:0] pcInc, pcNext, arNext, xecAddr, nztAddr;
	assign execEdge = (cnt_q == PH_EXEC);
	assign nzTaken = (op == OP_BRANCH_NONZERO) && (srcData != 8'h00);
	assign pcInc = pc_q + 13'h0001;
	assign xecAddr = srcIsReg ? {pc_q[12:8], aluOut} : {pc_q[12:5], aluOut[4:0]};
	assign nztAddr = srcIsReg ? {pc_q[12:8], literal} : {pc_q[12:5], literal[4:0]};
	always_comb begin
		case (1'b1)
			(op == OP_JUMP_ABSOLUTE): begin
				pcNext = instr_q[12:0];
				arNext = instr_q[12:0];
			end
			(op == OP_EXEC_INDEXED): begin
				pcNext = pc_q;
				arNext = xecAddr;
			end
			nzTaken: begin
				pcNext = nztAddr;
				arNext = nztAddr;
			end
			default: begin
				pcNext = pcInc;
				arNext = pcInc;
			end
		endcase
	end

	// ============================================================
	// Phase outputs, registered one clock ahead
	logic [2:0] cntD;
	logic inWin, outWin, latchWin, selLeftD, selRightD, addrStbD, wrStbD;
	assign cntD = cnt_q + 3'h1;
	assign inWin = (cntD >= PH_IN_FIRST) && (cntD <= PH_EXEC);
	assign outWin = (cntD >= PH_OUT_FIRST);
	assign latchWin = (cntD >= PH_LATCH_FIRST);
	assign selLeftD = (inWin && hasSrc && !srcIsReg && !srcRight) ||
		(outWin && ((dstBus && !dstRight) || (dstBankAddr && dstCode[3:0] == REG_LEFT_BANK_ADDR)));
	assign selRightD = (inWin && hasSrc && !srcIsReg && srcRight) ||
		(outWin && ((dstBus && dstRight) || (dstBankAddr && dstCode[3:0] == REG_RIGHT_BANK_ADDR)));
	assign addrStbD = outWin && dstBankAddr;
	assign wrStbD = outWin && (dstBus || litToBus);

	// ============================================================
	// Sequencer and synchronisers
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			cnt_q <= PH_FETCH;
			instrS1_q <= INSTR_RESET;
			instrS2_q <= INSTR_RESET;
			ioS1_q <= REG_RESET;
			ioS2_q <= REG_RESET;
		end else begin
			cnt_q <= cntD;
			instrS1_q <= instrIn;
			instrS2_q <= instrS1_q;
			ioS1_q <= ioDataBusIn;
			ioS2_q <= ioS1_q;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			instr_q <= INSTR_RESET;
		end else begin
			if (cnt_q == PH_FETCH) begin
				instr_q <= instrS2_q;
			end
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			pc_q <= PC_RESET;
			progAddr <= PC_RESET;
		end else if (execEdge) begin
			pc_q <= pcNext;
			progAddr <= arNext;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			leftBankSelectN <= 1'b1;
			rightBankSelectN <= 1'b1;
			addressStrobeCmd <= 1'b0;
			writeStrobeCmd <= 1'b0;
			masterLatchClock <= 1'b0;
			ioDataBusOe <= 1'b0;
			ioDataBusOut <= REG_RESET;
		end else begin
			leftBankSelectN <= !selLeftD;
			rightBankSelectN <= !selRightD;
			addressStrobeCmd <= addrStbD;
			writeStrobeCmd <= wrStbD;
			masterLatchClock <= latchWin;
			ioDataBusOe <= addrStbD || wrStbD;
			if (execEdge) begin
				ioDataBusOut <= dstBus ? mergedOut : aluOut;
			end
		end
	end

	// ============================================================
	// APB slave, one wait state
	logic apbAccess, regHit, apbWrReg;
	logic [3:0] apbIdx;
	assign apbAccess = psel && penable && pready;
	assign regHit = (paddr <= ADDR_REG_LAST) && (paddr[1:0] == 2'h0);
	assign apbIdx = paddr[5:2];
	assign apbWrReg = apbAccess && pwrite && regHit;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready &&
				!(regHit || (!pwrite && (paddr == ADDR_PC_STATUS || paddr == ADDR_INSTR_STATUS)));
			if (psel && penable && !pready && !pwrite) begin
				prdata <= regHit ? {24'h00_0000, rf_q[apbIdx]} :
					(paddr == ADDR_PC_STATUS) ? {19'h0_0000, pc_q} :
					(paddr == ADDR_INSTR_STATUS) ? {16'h0000, instr_q} : 32'h0000_0000;
			end
		end
	end

	// ============================================================
	// Register file; instruction writes win over the bus
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++) begin : g_rf
			logic instrWr, ovfWr;
			assign instrWr = execEdge && dstWrite && (dstCode[3:0] == 4'(gi));
			assign ovfWr = execEdge && (op == OP_ADD) && (4'(gi) == REG_OVERFLOW);
			always_ff @(posedge core_clk or negedge resetn) begin
				if (!resetn) begin
					rf_q[gi] <= REG_RESET;
				end else if (instrWr) begin
					rf_q[gi] <= aluOut;
				end else if (ovfWr) begin
					rf_q[gi] <= {7'h00, sum[8]};
				end else if (apbWrReg && apbIdx == 4'(gi)) begin
					rf_q[gi] <= pwdata[7:0];
				end
			end
		end
	endgenerate

	// ============================================================
	// Checks
	strobe_pair_excl_a: assert property (!(addressStrobeCmd && writeStrobeCmd))
		else $error("address and write strobes high together");
	bank_select_excl_a: assert property (!(!leftBankSelectN && !rightBankSelectN))
		else $error("both bank selects low");
	latch_clock_quarter_a: assert property (masterLatchClock == (cnt_q >= PH_LATCH_FIRST))
		else $error("master latch clock outside fourth quarter");
	jump_load_a: assert property (execEdge && op == OP_JUMP_ABSOLUTE |=>
		progAddr == $past(instr_q[12:0]) && pc_q == $past(instr_q[12:0]))
		else $error("jump did not load target");
	sequential_incr_a: assert property (execEdge && isAluOp |=>
		pc_q == $past(pc_q) + 13'h0001 && progAddr == pc_q)
		else $error("sequential address not incremented");
	exec_keeps_pc_a: assert property (execEdge && op == OP_EXEC_INDEXED |=>
		pc_q == $past(pc_q) && progAddr[12:8] == $past(pc_q[12:8]))
		else $error("execute-indexed disturbed program counter");
	source_select_a: assert property (cnt_q == PH_IN_FIRST && hasSrc && !srcIsReg |->
		(srcRight ? !rightBankSelectN : !leftBankSelectN))
		else $error("source bank not selected in input phase");
	addr_out_a: assert property (execEdge && dstBankAddr |=>
		(addressStrobeCmd && ioDataBusOe && ioDataBusOut == rf_q[$past(dstCode[3:0])]) [*3])
		else $error("bank address output missing");
	rotate_keeps_src_a: assert property (execEdge && regToReg && srcCode != dstCode &&
		srcCode[3:0] != REG_OVERFLOW |=> rf_q[$past(srcCode[3:0])] == $past(srcReg))
		else $error("rotation altered source register");
	literal_out_a: assert property (execEdge && litToBus |=>
		writeStrobeCmd && ioDataBusOut == $past(literal) && rf_q[$past(dstCode[3:0])] == $past(rf_q[dstCode[3:0]]))
		else $error("literal transmit wrong");
	branch_load_a: assert property (execEdge && nzTaken |=> progAddr == pc_q &&
		pc_q[4:0] == $past(instr_q[4:0]) && pc_q[12:8] == $past(pc_q[12:8]))
		else $error("taken branch did not load literal");
	source_zero_fill_a: assert property (execEdge && hasSrc && !srcIsReg |->
		(srcData & ~mask) == 8'h00)
		else $error("bus source bits above field length not cleared");
	merge_keeps_a: assert property (execEdge && dstBus |=>
		(ioDataBusOut & ~$past(fieldMask)) == ($past(ioS2_q) & ~$past(fieldMask)))
		else $error("merge disturbed bits outside the field");
	dest_select_a: assert property (execEdge && dstBus |=>
		writeStrobeCmd && (dstRight ? !rightBankSelectN : !leftBankSelectN))
		else $error("destination bank not selected in output phase");

endmodule

`default_nettype wire

/* operand_decode_addr_gen_test.sv */
// Purpose: Self-checking bench for operand decode and next address forming
// Assumes: Registers reached over the APB debug map, program held in the partner
// Notes: Bits outside a written field with a register source are left unchecked
`timescale 1ns/1ps
`default_nettype none

module operand_decode_addr_gen_test import opdec_pkg::*; ;
	logic core_clk, resetn, psel, penable, pwrite, pready, pslverr, rerr, trOn;
	logic [7:0] paddr, ioDataBusIn, ioDataBusOut, lit, lit2, sl, sr, fm;
	logic [31:0] pwdata, prdata, rdat;
	logic [31:0] seed = 32'd85102;
	logic [15:0] instrIn;
	logic [12:0] progAddr, lastPa, tgt;
	logic ioDataBusOe, leftBankSelectN, rightBankSelectN, addressStrobeCmd, writeStrobeCmd, masterLatchClock;
	logic [7:0] rv [0:6];
	logic [2:0] r, p, q, l1, l2;
	logic [3:0] hi = 4'h0;
	logic [12:0] trace [$];
	logic [12:0] expTr [$];
	int num_errors = 0;
	int total_checks = 0;

	operand_decode_addr_gen operand_decode_addr_gen_inst (.core_clk, .resetn, .instrIn, .progAddr, .ioDataBusIn,
		.ioDataBusOut, .ioDataBusOe, .leftBankSelectN, .rightBankSelectN, .addressStrobeCmd, .writeStrobeCmd,
		.masterLatchClock, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
	storage_io_model storage_io_model_inst (.core_clk, .progAddr, .instrIn, .ioDataBusOut, .ioDataBusOe,
		.leftBankSelectN, .rightBankSelectN, .addressStrobeCmd, .writeStrobeCmd, .masterLatchClock, .ioDataBusIn);

	// ============================================================
	// Expectation helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [7:0] rotr(input logic [7:0] v, input logic [2:0] n);
		logic [15:0] w;
		w = {v, v} >> n;
		return w[7:0];
	endfunction
	function automatic logic [7:0] lenm(input logic [2:0] l);
		return (l == 3'h0) ? 8'hff : 8'((9'h001 << l) - 9'h001);
	endfunction

	// ============================================================
	// Bus and compare tasks
	task results();
		if (num_errors == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task chk(input logic [63:0] g, input logic [63:0] e);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %0t got %h expected %h", $time, g, e);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rdchk(input logic [3:0] i, input logic [7:0] e);
		apb(1'b0, {2'b00, i, 2'b00}, 32'h0000_0000);
		chk({rdat, rerr}, {24'h00_0000, e, 1'b0});
	endtask
	task ld(input logic [12:0] a, input logic [15:0] w);
		storage_io_model_inst.mem[a] <= w;
	endtask

	// ============================================================
	// Clock, watchdog and bus monitor
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		num_errors++;
		$display("BAD %0t run did not finish", $time);
		results();
	end
	always @(posedge core_clk) begin
		if (resetn && ((addressStrobeCmd && writeStrobeCmd) || !(leftBankSelectN || rightBankSelectN))) begin
			num_errors++;
			$display("BAD %0t strobe or select clash", $time);
		end
		if (masterLatchClock) begin
			hi <= hi + 4'h1;
		end else if (hi != 4'h0) begin
			chk(hi, 2);
			hi <= 4'h0;
		end
		if (trOn && progAddr !== lastPa) begin
			trace.push_back(progAddr);
			lastPa = progAddr;
		end
	end

	// ============================================================
	// Main sequence
	initial begin
		{resetn, psel, penable, pwrite, trOn, paddr, pwdata} = '0;
		for (int b = 0; b < 2; b++) begin
			for (int i = 0; i < 256; i++) begin
				repeat (8) seed = lfsr(seed);
				storage_io_model_inst.port[b][i] = seed[7:0];
			end
		end
		repeat (20) @(posedge core_clk);
		chk({progAddr, leftBankSelectN, rightBankSelectN, addressStrobeCmd, writeStrobeCmd, masterLatchClock,
			ioDataBusOe}, {13'h0000, 6'b110000});
		resetn <= 1'b1;
		apb(1'b0, 8'h48, 32'h0000_0000);
		chk({rdat, rerr}, 33'h0_0000_0001);
		apb(1'b1, 8'h44, 32'h0000_1234);
		chk(rerr, 1);
		rdchk(4'h1, 8'h00);
		for (logic [3:0] i = 4'h0; i < 4'h7; i++) begin
			repeat (8) seed = lfsr(seed);
			rv[i] = seed[7:0];
			apb(1'b1, {2'b00, i, 2'b00}, {24'h00_0000, rv[i]});
			rdchk(i, rv[i]);
		end
		repeat (32) seed = lfsr(seed);
		{lit2, lit, r, p, q, l1, l2} = {seed[30:15], seed[14:0]};
		lit[7] = 1'b1;
		sl = storage_io_model_inst.port[0][rv[1]];
		sr = storage_io_model_inst.port[1][rotr(rv[1], r)];
		tgt = {5'h01, lit};
		ld(13'h0100, {OP_MOVE, 5'h01, r, 5'h02});
		ld(13'h0101, {OP_ADD, 5'h03, 3'h0, 5'h04});
		ld(13'h0102, {OP_XOR, 5'h05, 3'h0, 5'h05});
		ld(13'h0103, {OP_AND, 5'h06, 3'h0, 5'h06});
		ld(13'h0104, {OP_MOVE, 5'h01, 3'h0, 5'h07});
		ld(13'h0105, {OP_MOVE, 5'h02, 3'h0, 5'h0f});
		ld(13'h0106, {OP_MOVE, 2'b10, p, l1, 5'h09});
		ld(13'h0107, {OP_MOVE, 5'h01, l2, 2'b10, q});
		ld(13'h0108, {OP_MOVE, 2'b11, p, l1, 2'b10, q});
		ld(13'h0109, {OP_TRANSMIT_LITERAL, 5'h0a, lit});
		ld(13'h010a, {OP_TRANSMIT_LITERAL, 5'h03, lit});
		ld(13'h010b, {OP_BRANCH_NONZERO, 5'h03, 8'h40});
		ld(13'h0140, {OP_BRANCH_NONZERO, 5'h0c, 8'h20});
		ld(13'h0141, {OP_EXEC_INDEXED, 5'h03, 8'h00});
		ld(tgt, {OP_TRANSMIT_LITERAL, 5'h0e, lit2});
		ld(13'h0142, {OP_JUMP_ABSOLUTE, 13'h1000});
		ld(13'h1000, {OP_JUMP_ABSOLUTE, 13'h1000});
		for (int a = 'h100; a < 'h10c; a++) begin
			expTr.push_back(13'(a));
		end
		expTr.push_back(13'h0140);
		expTr.push_back(13'h0141);
		expTr.push_back(tgt);
		expTr.push_back(13'h0142);
		expTr.push_back(13'h1000);
		@(posedge core_clk);
		lastPa = progAddr;
		trOn = 1'b1;
		ld(13'h0000, {OP_JUMP_ABSOLUTE, 13'h0100});
		for (int n = 0; n < 600 && progAddr !== 13'h1000; n++) begin
			@(posedge core_clk);
		end
		repeat (16) @(posedge core_clk);
		chk(progAddr, 13'h1000);
		chk(trace.size(), expTr.size());
		foreach (expTr[i]) chk(trace[i], expTr[i]);
		chk(storage_io_model_inst.wlog.size(), 5);
		chk(storage_io_model_inst.wlog[0], {4'b1001, rv[1]});
		chk(storage_io_model_inst.wlog[1], {4'b1010, rotr(rv[1], r)});
		fm = lenm(l2) << q;
		chk({storage_io_model_inst.wlog[2][11:8], storage_io_model_inst.wlog[2][7:0] & fm}, {4'b0101, (rv[1] << q) & fm});
		fm = lenm(l1) << q;
		chk(storage_io_model_inst.wlog[3], {4'b0101, (sr & ~fm) | (((rotr(sr, p) & lenm(l1)) << q) & fm)});
		chk(storage_io_model_inst.wlog[4], {4'b0111, lit});
		rdchk(4'h1, rv[1]);
		rdchk(4'h2, rotr(rv[1], r));
		rdchk(4'h4, rv[3] + rv[0]);
		rdchk(4'h5, rv[5] ^ rv[0]);
		rdchk(4'h6, rv[6] & rv[0]);
		rdchk(4'h7, rv[1]);
		rdchk(4'hf, rotr(rv[1], r));
		rdchk(4'h9, rotr(sl, p) & lenm(l1));
		rdchk(4'ha, 8'h00);
		rdchk(4'h3, lit);
		rdchk(4'he, lit2);
		results();
	end
endmodule

`default_nettype wire

/* storage_io_model.sv */
// Purpose: Program storage and two banks of I/O ports facing the decoder
// Assumes: Each bank holds 256 ports and one address latch loaded by the address strobe
// Notes: A released bus shows the inverse of its last level, so stale data never passes for good data
`timescale 1ns/1ps
`default_nettype none

module storage_io_model (
	input wire logic core_clk,
	input wire logic [12:0] progAddr,
	output logic [15:0] instrIn,
	input wire logic [7:0] ioDataBusOut,
	input wire logic ioDataBusOe,
	input wire logic leftBankSelectN,
	input wire logic rightBankSelectN,
	input wire logic addressStrobeCmd,
	input wire logic writeStrobeCmd,
	input wire logic masterLatchClock,
	output logic [7:0] ioDataBusIn
);
	logic [15:0] mem [0:8191];
	logic [7:0] port [0:1][0:255];
	logic [7:0] bankAddr [0:1];
	logic [7:0] lastBus;
	logic [11:0] wlog [$];
	wire idle = !addressStrobeCmd && !writeStrobeCmd;
	wire bank = leftBankSelectN;
	wire sel = !leftBankSelectN || !rightBankSelectN;

	// ============================================================
	// Storage answers at once; every empty word jumps home
	initial begin
		for (int i = 0; i < 8192; i++) begin
			mem[i] = 16'he000;
		end
		bankAddr[0] = 8'h00;
		bankAddr[1] = 8'h00;
		lastBus = 8'h00;
	end
	assign instrIn = mem[progAddr];

	// ============================================================
	// Bus level: the device, a selected port, or a changing pattern
	assign ioDataBusIn = ioDataBusOe ? ioDataBusOut : (sel && idle) ? port[bank][bankAddr[bank]] : ~lastBus;
	always @(posedge core_clk) begin
		lastBus <= ioDataBusIn;
	end

	// ============================================================
	// Peripherals capture on the latch clock
	always @(posedge masterLatchClock) begin
		if (!idle) begin
			wlog.push_back({addressStrobeCmd, writeStrobeCmd, leftBankSelectN, rightBankSelectN, ioDataBusOut});
			if (sel && addressStrobeCmd) begin
				bankAddr[bank] <= ioDataBusOut;
			end
			if (sel && writeStrobeCmd) begin
				port[bank][bankAddr[bank]] <= ioDataBusOut;
			end
		end
	end
endmodule

`default_nettype wire
